// ==== odsl_pkg.sv ====
// Shared constants for the octal converter serial loader.
package odsl_pkg;

    // ==========================================
    // Word layout
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 4;
    localparam int ADDR_POS = 3;
    localparam int SEL_BITS = 3;
    localparam int SEL_MSB = 2;
    localparam int CHANNELS = 8;
    localparam logic [3:0] LAST_BIT_CNT = 4'hf;

    // ==========================================
    // Synchroniser lanes
    localparam int SYNC_LANES = 6;
    localparam int LANE_CLK = 5;
    localparam int LANE_FS = 4;
    localparam int LANE_SD = 3;
    localparam int LANE_ADDR = 2;
    localparam int LANE_LOAD = 1;
    localparam int LANE_CLR = 0;
    localparam logic [5:0] SYNC_RESET = 6'h1b;

    // ==========================================
    // Reset values and buffering
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int FIFO_DEPTH = 8;

    // ==========================================
    // Receiver phases
    typedef enum logic [1:0] {
        ODSL_RX_IDLE = 2'b00,
        ODSL_RX_SHIFT = 2'b01,
        ODSL_RX_DONE = 2'b10
    } odsl_rx_t;

endpackage : odsl_pkg

// ==== odsl_fifo.sv ====
// Word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module odsl_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    // ==========================================
    // Storage and pointers
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire logic full = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
        && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire logic empty = (wr_ptr_reg == rd_ptr_reg);
    wire logic push = in_valid && !full;
    wire logic pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end

endmodule : odsl_fifo

// ==== odsl_loader.sv ====
// Serial loader, input latches and converter latches of the octal converter.
//
// Contract
// - Serial data is sampled into the shift register on falling shift clock edges within a frame, up to sixteen of them.
// - The host opens a frame by pulling frame sync low and shifting happens only while it is low.
// - On the sixteenth falling edge after frame sync falls, a matching word loads the 12-bit code.
// - A frame is a 16-bit word sent most significant bit first with the code in bits 15 to 4.
// - After the code comes one address bit that is compared with the address pin.
// - A word whose bit 3 differs from the address pin loads nothing but still shifts onward.
// - The shift register contents leave on the chain output so devices can be cascaded.
// - While load is low and clear is high every input latch is copied into its converter latch at once.
// - While clear is low all eight converter latches are forced to zero.
// - Select bits 2 to 0 pick channels in ascending binary, 000 first and 111 eighth.
// - After sixteen bits the shift register stops loading until frame sync falls again.
// - Each bit shifted out of bit 15 moves to the chain output on the following rising shift clock edge.
// - Clear leaves the input latches alone so a later load restores the old codes.
`timescale 1ns/1ps
module odsl_loader #(
    parameter int CHANNELS = odsl_pkg::CHANNELS,
    parameter int CODE_BITS = odsl_pkg::CODE_BITS,
    parameter int FIFO_DEPTH = odsl_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serial_shift_clock,
    input wire logic frame_sync_n,
    input wire logic serial_data_in,
    input wire logic device_address_pin,
    input wire logic latch_update_n,
    input wire logic converter_clear_n,
    output logic chain_data_out,
    output logic [CHANNELS*CODE_BITS-1:0] converter_code,
    output logic word_accepted,
    output logic load_overrun
);

    localparam int SEL_BITS = odsl_pkg::SEL_BITS;
    localparam int FW = CODE_BITS + SEL_BITS;

    // ==========================================
    // Input synchronisers
    logic [odsl_pkg::SYNC_LANES-1:0] sync1_reg;
    logic [odsl_pkg::SYNC_LANES-1:0] sync2_reg;
    logic clk_d_reg;
    logic fs_d_reg;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_reg <= odsl_pkg::SYNC_RESET;
            sync2_reg <= odsl_pkg::SYNC_RESET;
            clk_d_reg <= 1'b0;
            fs_d_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= {serial_shift_clock, frame_sync_n, serial_data_in,
                device_address_pin, latch_update_n, converter_clear_n};
            sync2_reg <= sync1_reg;
            clk_d_reg <= sync2_reg[odsl_pkg::LANE_CLK];
            fs_d_reg <= sync2_reg[odsl_pkg::LANE_FS];
        end
    end

    wire logic clk_s = sync2_reg[odsl_pkg::LANE_CLK];
    wire logic fs_s = sync2_reg[odsl_pkg::LANE_FS];
    wire logic sd_s = sync2_reg[odsl_pkg::LANE_SD];
    wire logic addr_s = sync2_reg[odsl_pkg::LANE_ADDR];
    wire logic load_low = !sync2_reg[odsl_pkg::LANE_LOAD];
    wire logic clear_low = !sync2_reg[odsl_pkg::LANE_CLR];
    wire logic clk_fall = clk_d_reg && !clk_s;
    wire logic clk_rise = !clk_d_reg && clk_s;
    wire logic fs_fall = fs_d_reg && !fs_s;

    // ==========================================
    // Receiver
    odsl_pkg::odsl_rx_t rx_reg;
    odsl_pkg::odsl_rx_t rx_next;
    logic [3:0] bit_cnt_reg;
    logic [odsl_pkg::WORD_BITS-1:0] shift_reg;
    logic out_bit_reg;
    logic chain_reg;

    wire logic shift_en = clk_fall && !fs_s
        && (fs_fall || rx_reg == odsl_pkg::ODSL_RX_SHIFT);
    wire logic [3:0] cnt_base = fs_fall ? 4'h0 : bit_cnt_reg;
    wire logic word_done = shift_en && (cnt_base == odsl_pkg::LAST_BIT_CNT);
    wire logic [odsl_pkg::WORD_BITS-1:0] word_full = {shift_reg[odsl_pkg::WORD_BITS-2:0], sd_s};
    wire logic addr_match = (word_full[odsl_pkg::ADDR_POS] == addr_s);
    wire logic [CODE_BITS-1:0] word_code = word_full[odsl_pkg::CODE_MSB:odsl_pkg::CODE_LSB];
    wire logic [SEL_BITS-1:0] word_sel = word_full[odsl_pkg::SEL_MSB:0];

    always_comb
    begin
        rx_next = rx_reg;
        unique case (rx_reg)
            odsl_pkg::ODSL_RX_IDLE:
            begin
                if (fs_fall)
                begin
                    rx_next = odsl_pkg::ODSL_RX_SHIFT;
                end
            end
            odsl_pkg::ODSL_RX_SHIFT:
            begin
                if (fs_s)
                begin
                    rx_next = odsl_pkg::ODSL_RX_IDLE;
                end
                else if (word_done)
                begin
                    rx_next = odsl_pkg::ODSL_RX_DONE;
                end
            end
            odsl_pkg::ODSL_RX_DONE:
            begin
                if (fs_s)
                begin
                    rx_next = odsl_pkg::ODSL_RX_IDLE;
                end
            end
            default:
            begin
                rx_next = odsl_pkg::ODSL_RX_IDLE;
            end
        endcase
        if (fs_fall && word_done)
        begin
            rx_next = odsl_pkg::ODSL_RX_DONE;
        end
        else if (fs_fall)
        begin
            rx_next = odsl_pkg::ODSL_RX_SHIFT;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_reg <= odsl_pkg::ODSL_RX_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= odsl_pkg::WORD_RESET;
            out_bit_reg <= 1'b0;
            chain_reg <= 1'b0;
        end
        else
        begin
            rx_reg <= rx_next;
            if (fs_fall || shift_en)
            begin
                bit_cnt_reg <= shift_en ? cnt_base + 4'h1 : 4'h0;
            end
            if (shift_en)
            begin
                shift_reg <= word_full;
                out_bit_reg <= shift_reg[odsl_pkg::WORD_BITS-1];
            end
            if (clk_rise)
            begin
                chain_reg <= out_bit_reg;
            end
        end
    end

    assign chain_data_out = chain_reg;

    // ==========================================
    // Word hand-off into the FIFO
    logic pend_valid_reg;
    logic [FW-1:0] pend_word_reg;
    logic accepted_reg;
    logic overrun_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FW-1:0] fifo_out_data;

    wire logic take_word = word_done && addr_match;
    wire logic pend_free = !pend_valid_reg || fifo_in_ready;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_valid_reg <= 1'b0;
            pend_word_reg <= '0;
            accepted_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            accepted_reg <= take_word && pend_free;
            if (take_word && pend_free)
            begin
                pend_valid_reg <= 1'b1;
                pend_word_reg <= {word_code, word_sel};
            end
            else if (fifo_in_ready)
            begin
                pend_valid_reg <= 1'b0;
            end
            if (take_word && !pend_free)
            begin
                overrun_reg <= 1'b1;
            end
            else if (fs_fall)
            begin
                overrun_reg <= 1'b0;
            end
        end
    end

    assign word_accepted = accepted_reg;
    assign load_overrun = overrun_reg;

    // Input latch writes stall while load copies, keeping the copy coherent.
    wire logic drain_ready = !load_low;
    wire logic drain = fifo_out_valid && drain_ready;
    wire logic [SEL_BITS-1:0] drain_sel = fifo_out_data[SEL_BITS-1:0];
    wire logic [CODE_BITS-1:0] drain_code = fifo_out_data[FW-1:SEL_BITS];

    odsl_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_data(pend_word_reg),
        .in_valid(pend_valid_reg),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(drain_ready)
    );

    // ==========================================
    // Input and converter latches
    logic [CODE_BITS-1:0] in_latch_reg [CHANNELS];
    logic [CODE_BITS-1:0] dac_reg [CHANNELS];
    logic [CHANNELS*CODE_BITS-1:0] in_flat;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_ch
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    in_latch_reg[ch] <= odsl_pkg::CODE_RESET;
                    dac_reg[ch] <= odsl_pkg::CODE_RESET;
                end
                else
                begin
                    if (drain && drain_sel == SEL_BITS'(ch))
                    begin
                        in_latch_reg[ch] <= drain_code;
                    end
                    if (clear_low)
                    begin
                        dac_reg[ch] <= odsl_pkg::CODE_RESET;
                    end
                    else if (load_low)
                    begin
                        dac_reg[ch] <= in_latch_reg[ch];
                    end
                end
            end
            assign converter_code[ch*CODE_BITS +: CODE_BITS] = dac_reg[ch];
            assign in_flat[ch*CODE_BITS +: CODE_BITS] = in_latch_reg[ch];
        end
    endgenerate

    // ==========================================
    // Assertions
    sample_shift_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        shift_en |=> shift_reg == {$past(shift_reg[odsl_pkg::WORD_BITS-2:0]), $past(sd_s)})
        else $error("shift register did not take the sampled bit");

    frame_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fs_s |=> shift_reg == $past(shift_reg))
        else $error("shifting while frame sync is high");

    word_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (shift_en && !fs_fall && bit_cnt_reg == 4'hf)
            |-> word_done ##1 rx_reg == odsl_pkg::ODSL_RX_DONE)
        else $error("sixteenth bit did not complete a word");

    word_take_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (take_word && pend_free) |=> pend_valid_reg && accepted_reg
            && pend_word_reg == $past({word_code, word_sel}))
        else $error("matching word not handed on");

    addr_drop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (word_done && !addr_match && !pend_valid_reg) |=> !pend_valid_reg && !accepted_reg)
        else $error("mismatched word was accepted");

    stop_full_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_reg == odsl_pkg::ODSL_RX_DONE |=> shift_reg == $past(shift_reg))
        else $error("shift register loaded after sixteen bits");

    chain_rise_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_rise |=> chain_data_out == $past(out_bit_reg))
        else $error("chain output missed the rising edge");

    load_copy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (load_low && !clear_low) |=> converter_code == $past(in_flat))
        else $error("load did not copy the input latches");

    clear_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clear_low |=> converter_code == '0)
        else $error("clear did not zero the converter latches");

    clear_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (clear_low && !drain) |=> in_flat == $past(in_flat))
        else $error("clear disturbed the input latches");

endmodule : odsl_loader

// ==== odsl_host.sv ====
// Host model that shifts frames into the serial loader.
`timescale 1ns/1ps
module odsl_host (
    output logic serial_shift_clock,
    output logic frame_sync_n,
    output logic serial_data_in,
    input wire logic chain_data_out
);
    // ==========================================
    // Frame driver
    logic [15:0] echo;
    initial
    begin
        serial_shift_clock = 1'b0;
        frame_sync_n = 1'b1;
        serial_data_in = 1'b0;
        echo = 16'h0000;
    end
    task automatic send(input logic [15:0] w, input int n);
        logic b;
        b = 1'b0;
        frame_sync_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            b = (i < 16) ? w[15-i] : i[0];
            #31.25 serial_data_in = b;
            #31.25 serial_shift_clock = 1'b1;
            #62.5 serial_shift_clock = 1'b0;
            echo = {echo[14:0], chain_data_out};
        end
        #31.25 frame_sync_n = 1'b1;
        serial_data_in = ~b;
        #62.5;
    endtask : send
endmodule : odsl_host

// ==== testbench.sv ====
// Self-checking testbench for the octal converter serial loader.
`timescale 1ns/1ps
module testbench;
    // ==========================================
    // Signals and instances
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic device_address_pin = 1'b0;
    logic latch_update_n = 1'b1;
    logic converter_clear_n = 1'b1;
    logic serial_shift_clock;
    logic frame_sync_n;
    logic serial_data_in;
    logic chain_data_out;
    logic [95:0] converter_code;
    logic word_accepted;
    logic load_overrun;
    logic [11:0] exp_in [8];
    logic [15:0] last_word = 16'h0000;
    int bad_count = 0;
    int total_checks = 0;
    int accepted = 0;
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk)
    begin
        if (word_accepted === 1'b1)
        begin
            accepted++;
        end
    end
    odsl_loader u_dut (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .serial_shift_clock(serial_shift_clock),
        .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in),
        .device_address_pin(device_address_pin),
        .latch_update_n(latch_update_n),
        .converter_clear_n(converter_clear_n),
        .chain_data_out(chain_data_out),
        .converter_code(converter_code),
        .word_accepted(word_accepted),
        .load_overrun(load_overrun)
    );
    odsl_host u_host (
        .serial_shift_clock(serial_shift_clock),
        .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in),
        .chain_data_out(chain_data_out)
    );
    // ==========================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check_code(input logic [95:0] got, input logic [95:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected code at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_code
    task automatic check_flag(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_flag
    function automatic logic [95:0] packed_codes();
        logic [95:0] p;
        for (int c = 0; c < 8; c++)
        begin
            p[c*12 +: 12] = exp_in[c];
        end
        return p;
    endfunction : packed_codes
    task automatic send_chk(input logic [15:0] w, input int n);
        u_host.send(w, n);
        if (n == 16)
        begin
            check_flag({1'b0, u_host.echo[14:0]}, {1'b0, last_word[15:1]});
        end
        last_word = w;
    endtask : send_chk
    task automatic update_latches;
        latch_update_n = 1'b0;
        tick(4);
        latch_update_n = 1'b1;
        tick(4);
    endtask : update_latches
    // ==========================================
    // Scenarios
    task automatic t_channels;
        for (int c = 0; c < 8; c++)
        begin
            exp_in[c] = 12'(12'h9c3 + 12'h1f1 * c);
            send_chk({exp_in[c], 1'b0, 3'(c)}, 16);
        end
        tick(4);
        check_flag(16'(accepted), 16'h0008);
        check_code(converter_code, '0);
        update_latches();
        check_code(converter_code, packed_codes());
    endtask : t_channels
    task automatic t_address;
        int n0;
        device_address_pin = 1'b1;
        tick(4);
        n0 = accepted;
        send_chk({12'h3c5, 1'b0, 3'h2}, 16);
        tick(4);
        check_flag(16'(accepted - n0), 16'h0000);
        exp_in[5] = 12'h7e1;
        send_chk({exp_in[5], 1'b1, 3'h5}, 16);
        tick(4);
        check_flag(16'(accepted - n0), 16'h0001);
        update_latches();
        check_code(converter_code, packed_codes());
        device_address_pin = 1'b0;
    endtask : t_address
    task automatic t_clear;
        converter_clear_n = 1'b0;
        tick(4);
        check_code(converter_code, '0);
        latch_update_n = 1'b0;
        tick(4);
        check_code(converter_code, '0);
        converter_clear_n = 1'b1;
        tick(4);
        check_code(converter_code, packed_codes());
        latch_update_n = 1'b1;
        tick(2);
    endtask : t_clear
    task automatic t_overlong;
        exp_in[0] = 12'h5a6;
        send_chk({exp_in[0], 1'b0, 3'h0}, 20);
        update_latches();
        check_code(converter_code, packed_codes());
    endtask : t_overlong
    task automatic t_overrun;
        latch_update_n = 1'b0;
        tick(4);
        for (int k = 1; k <= 10; k++)
        begin
            send_chk({12'(k), 1'b0, 3'h3}, 16);
            if (k == 9)
            begin
                check_flag({15'h0000, load_overrun}, 16'h0000);
            end
        end
        tick(4);
        check_flag({15'h0000, load_overrun}, 16'h0001);
        latch_update_n = 1'b1;
        tick(40);
        exp_in[3] = 12'h009;
        update_latches();
        check_code(converter_code, packed_codes());
    endtask : t_overrun
    // ==========================================
    // Run control
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (16) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        tick(4);
        check_code(converter_code, '0);
        t_channels();
        t_address();
        t_clear();
        t_overlong();
        t_overrun();
        stop_test();
    end
    initial
    begin
        #400000;
        bad_count++;
        stop_test();
    end
endmodule : testbench
